/* File: design/dac_clock_config.sv */
// Contract
// R1: Oversampling 256, 128, 64 by rate range
// R2: Per-channel attenuator, 255 steps of 0.375 dB
// R3: Six stereo inputs or one TDM line
// R4: Rate code 0b11 shortens filtering, lower delay
// R5: Per-channel tier field picks bias level
// R6: Nonzero global tier overrides all channels
// R7: Standalone pin sampled once after reset
// R8: Serial clocks slave by default; partner supplies clocks
// R9: Clock-out select resets to buffer; 0b11 off
// R10: Codes 0b00/0b01 give divided low-jitter clock
// R11: Host programs clock registers after reset release
// R12: PLL accepts 256/384/512/768 times sample rate
// R13: Effective ratio halves at 96k, quarters 192k
// R14: Core clock 512, 256, 128 times rate
// R15: PLL enabled straight out of reset
// R16: Host waits for PLL lock before audio
// R17: Direct clock: PLL down, select bit, 512x
// R18: PLL source 0b01 locks to frame clock
// R19: Ratio codes 0b00..0b11 map 256..768
`timescale 1ns/1ps
module dac_clock_config
   import dac_clock_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_spi_select_n,
   input wire logic i_spi_clock,
   input wire logic i_spi_data_in,
   output logic o_spi_data_out,
   output logic o_spi_data_out_oe,
   input wire logic i_standalone_select,
   input wire logic i_master_clock_in,
   input wire logic i_frame_clock_in,
   input wire logic [3:0] i_atten_channel,
   output logic [7:0] o_atten_level,
   output logic o_master_clock_out,
   output logic o_pll_reference,
   output logic o_pll_enable,
   output logic o_direct_clock,
   output logic o_powered_up,
   output logic o_standalone,
   output logic o_serial_master,
   output logic o_serial_tdm,
   output logic o_short_filter,
   output logic [8:0] o_oversample_ratio,
   output logic [9:0] o_core_clock_ratio,
   output logic [9:0] o_effective_mclk_ratio,
   output logic [31:0] o_channel_tier
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] spi_meta, spi_sync;
   logic [2:0] pin_meta, pin_sync;
   logic sclk_prev, mck_prev;

   // Two flops on every pin; only the second stage is looked at
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         spi_meta <= 3'h7;
         spi_sync <= 3'h7;
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
         sclk_prev <= 1'b0;
         mck_prev <= 1'b0;
      end else begin
         spi_meta <= {i_spi_select_n, i_spi_clock, i_spi_data_in};
         spi_sync <= spi_meta;
         pin_meta <= {i_standalone_select, i_master_clock_in, i_frame_clock_in};
         pin_sync <= pin_meta;
         sclk_prev <= spi_sync[1];
         mck_prev <= pin_sync[1];
      end
   end

   wire sel_active = ~spi_sync[2];
   wire sclk_rise = spi_sync[1] & ~sclk_prev;
   wire sclk_fall = ~spi_sync[1] & sclk_prev;
   wire mosi = spi_sync[0];
   wire sa_sync = pin_sync[2];
   wire mck_sync = pin_sync[1];
   wire frm_sync = pin_sync[0];
   wire mck_edge = mck_sync ^ mck_prev;

   // ----------------------------------------------------------------
   // Standalone strap capture
   // ----------------------------------------------------------------
   logic [1:0] sa_count;
   logic sa_ready, standalone;

   // Wait for the synchroniser to fill before trusting the strap
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sa_count <= 2'h0;
         sa_ready <= 1'b0;
         standalone <= 1'b0;
      end else if (!sa_ready) begin
         sa_count <= sa_count + 2'h1;
         if (sa_count == SA_SETTLE_CYCLES) begin
            sa_ready <= 1'b1; // [R7]
            standalone <= sa_sync; // [R7]
         end
      end
   end

   // ----------------------------------------------------------------
   // Control port: 16-bit frame, read flag, address, data
   // ----------------------------------------------------------------
   spi_state_type state, next_state;
   logic [4:0] bit_count;
   logic [14:0] shift_in;
   logic [6:0] addr;
   logic is_read, load_pending;
   logic [7:0] shift_out;

   // Frame sequencing; deselect aborts from any state
   always_comb begin
      next_state = state;
      case (state)
         SPI_IDLE: if (sel_active) next_state = SPI_ADDR;
         SPI_ADDR: begin
            if (!sel_active) next_state = SPI_IDLE;
            else if (sclk_rise && bit_count == SPI_ADDR_LAST_BIT) next_state = SPI_DATA;
         end
         SPI_DATA: begin
            if (!sel_active) next_state = SPI_IDLE;
            else if (sclk_rise && bit_count == SPI_FRAME_LAST_BIT) next_state = SPI_WAIT;
         end
         SPI_WAIT: if (!sel_active) next_state = SPI_IDLE;
         default: next_state = SPI_IDLE;
      endcase
   end

   wire in_frame = (state == SPI_ADDR) || (state == SPI_DATA);
   wire addr_done = (state == SPI_ADDR) && sel_active && sclk_rise
      && bit_count == SPI_ADDR_LAST_BIT;
   wire [7:0] wr_data = {shift_in[6:0], mosi};
   // Writes are locked out in standalone mode and before the strap is taken
   wire wr_en = (state == SPI_DATA) && sel_active && sclk_rise
      && bit_count == SPI_FRAME_LAST_BIT && !is_read && sa_ready && !standalone;

   // Shift in on rising edges of the serial clock
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= SPI_IDLE;
         bit_count <= 5'h0;
         shift_in <= 15'h0;
         addr <= 7'h0;
         is_read <= 1'b0;
      end else begin
         state <= next_state;
         if (!in_frame) begin
            bit_count <= 5'h0;
         end else if (sclk_rise) begin
            bit_count <= bit_count + 5'h1;
            shift_in <= {shift_in[13:0], mosi};
         end
         if (addr_done) begin
            addr <= {shift_in[5:0], mosi};
            is_read <= shift_in[6];
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] pll_ctrl0, pll_ctrl1, conv_ctrl0, block_pdn;
   logic [31:0] tier_bits;

   wire [1:0] tier_index = 2'(addr - OFS_TIER_FIRST);
   wire sel_tier = (addr >= OFS_TIER_FIRST) && (addr <= OFS_TIER_LAST);
   wire sel_atten = (addr[6:4] == OFS_ATTEN_PAGE);

   // Host-programmed state; strap mode leaves all at defaults
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pll_ctrl0 <= PLL_CTRL0_RST;
         pll_ctrl1 <= PLL_CTRL1_RST; // [R9]
         conv_ctrl0 <= CONV_CTRL0_RST; // [R8]
         block_pdn <= BLOCK_PDN_RST; // [R15]
         tier_bits <= TIER_RST; // [R5]
      end else if (wr_en) begin
         if (addr == OFS_PLL_CTRL0) pll_ctrl0 <= wr_data;
         if (addr == OFS_PLL_CTRL1) pll_ctrl1 <= wr_data;
         if (addr == OFS_CONV_CTRL0) conv_ctrl0 <= wr_data;
         if (addr == OFS_BLOCK_PDN) block_pdn <= wr_data;
         if (sel_tier) tier_bits[8*tier_index +: 8] <= wr_data;
      end
   end

   // Per-channel attenuator levels, index is the low address nibble
   logic [7:0] atten_rd;

   atten_store #(
      .DEPTH(NUM_CHANNELS),
      .WIDTH(8),
      .INDEX_BITS(4)
   ) u_atten (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_write(wr_en && sel_atten), // [R2]
      .i_write_index(addr[3:0]),
      .i_write_data(wr_data),
      .i_read_index_a(addr[3:0]),
      .o_read_data_a(atten_rd),
      .i_read_index_b(i_atten_channel),
      .o_read_data_b(o_atten_level) // [R2]
   );

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   wire [1:0] ratio_code = pll_ctrl0[CTRL0_MRS_LSB +: 2];
   wire [1:0] pll_source = pll_ctrl0[CTRL0_SRC_LSB +: 2];
   wire [1:0] mco_select = pll_ctrl1[CTRL1_MCO_LSB +: 2];
   wire [1:0] global_tier = pll_ctrl1[CTRL1_TIER_LSB +: 2];
   wire [1:0] rate_code = conv_ctrl0[CONV_SR_LSB +: 2];
   wire pll_down = block_pdn[PDN_PLL_BIT];
   wire direct_req = pll_ctrl1[CTRL1_DIRECT_BIT] && pll_down;
   // Both 192 kHz codes quarter the ratio
   wire [1:0] rate_shift = (rate_code == SR_48K) ? 2'h0 : (rate_code == SR_96K) ? 2'h1 : 2'h2;
   wire [9:0] mcs_ratio = (ratio_code == 2'h0) ? MCS_RATIO_0 : // [R19]
      (ratio_code == 2'h1) ? MCS_RATIO_1 :
      (ratio_code == 2'h2) ? MCS_RATIO_2 : MCS_RATIO_3;
   wire [9:0] base_ratio = direct_req ? DIRECT_RATIO : mcs_ratio; // [R17]

   // Divide in master-clock edges; one edge per half period of the input
   wire [2:0] div_low = (ratio_code == 2'h0) ? 3'h2 : (ratio_code == 2'h1) ? 3'h3 :
      (ratio_code == 2'h2) ? 3'h4 : 3'h6;
   wire [2:0] div_high = (ratio_code == 2'h0) ? 3'h1 : (ratio_code == 2'h3) ? 3'h3 : 3'h2;
   wire [2:0] div_edges = (mco_select == MCO_LOWJIT_LOW) ? div_low : div_high; // [R10]

   // Read mux; unmapped addresses read zero
   wire [7:0] status = {2'h0, sa_ready, standalone, o_direct_clock, o_pll_enable, rate_shift};
   wire [7:0] rd_data = (addr == OFS_PLL_CTRL0) ? pll_ctrl0 :
      (addr == OFS_PLL_CTRL1) ? pll_ctrl1 :
      (addr == OFS_CONV_CTRL0) ? conv_ctrl0 :
      sel_tier ? tier_bits[8*tier_index +: 8] :
      (addr == OFS_BLOCK_PDN) ? block_pdn :
      (addr == OFS_STATUS) ? status :
      sel_atten ? atten_rd : 8'h00;

   // ----------------------------------------------------------------
   // Read data out, shifted on falling serial clock edges
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         load_pending <= 1'b0;
         shift_out <= 8'h00;
         o_spi_data_out <= 1'b0;
         o_spi_data_out_oe <= 1'b0;
      end else begin
         o_spi_data_out_oe <= sel_active && is_read
            && (state == SPI_DATA || state == SPI_WAIT);
         if (addr_done) begin
            load_pending <= 1'b1;
         end else if (sclk_fall && state == SPI_DATA) begin
            load_pending <= 1'b0;
            shift_out <= load_pending ? {rd_data[6:0], 1'b0} : {shift_out[6:0], 1'b0};
            o_spi_data_out <= load_pending ? rd_data[7] : shift_out[7];
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock control outputs
   // ----------------------------------------------------------------
   logic [2:0] edge_count;
   logic div_clock;

   // Edge counting gives odd ratios too, with a 50 % duty cycle
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         edge_count <= 3'h0;
         div_clock <= 1'b0;
      end else if (mck_edge) begin
         if (edge_count + 3'h1 >= div_edges) begin
            edge_count <= 3'h0;
            div_clock <= ~div_clock; // [R10]
         end else begin
            edge_count <= edge_count + 3'h1;
         end
      end
   end

   // Clock-out mux, reference selection and ratios
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_master_clock_out <= 1'b0;
         o_pll_reference <= 1'b0;
         o_pll_enable <= 1'b0;
         o_direct_clock <= 1'b0;
         o_powered_up <= 1'b0;
         o_standalone <= 1'b0;
         o_serial_master <= 1'b0;
         o_serial_tdm <= 1'b0;
         o_short_filter <= 1'b0;
         o_oversample_ratio <= OSR_48K;
         o_core_clock_ratio <= CORE_RATIO_48K;
         o_effective_mclk_ratio <= MCS_RATIO_0;
      end else begin
         o_master_clock_out <= (mco_select == MCO_BUFFER) ? mck_sync : // [R9]
            (mco_select == MCO_OFF) ? 1'b0 : div_clock; // [R9] [R10]
         o_pll_reference <= (pll_source == SRC_FRAME) ? frm_sync : mck_sync; // [R18]
         o_pll_enable <= !pll_down; // [R15]
         o_direct_clock <= direct_req; // [R17]
         o_powered_up <= pll_ctrl0[CTRL0_PUP_BIT];
         o_standalone <= standalone; // [R7]
         o_serial_master <= conv_ctrl0[CONV_MASTER_BIT]; // [R8]
         o_serial_tdm <= conv_ctrl0[CONV_TDM_BIT]; // [R3]
         o_short_filter <= (rate_code == SR_192K_LOWDELAY); // [R4]
         o_oversample_ratio <= OSR_48K >> rate_shift; // [R1]
         o_core_clock_ratio <= CORE_RATIO_48K >> rate_shift; // [R14]
         o_effective_mclk_ratio <= base_ratio >> rate_shift; // [R12] [R13]
      end
   end

   // Global field, when not zero, replaces every channel's own field
   for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_tier
      always_ff @(posedge i_clock or negedge i_rst_n) begin
         if (!i_rst_n) begin
            o_channel_tier[2*ch +: 2] <= TIER_INDIVIDUAL;
         end else begin
            o_channel_tier[2*ch +: 2] <= (global_tier != TIER_INDIVIDUAL) ? // [R6]
               global_tier : tier_bits[2*ch +: 2]; // [R5]
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   sequence s_tier_write;
      wr_en && sel_tier && (global_tier == TIER_INDIVIDUAL);
   endsequence
   property p_channel_tier;
      s_tier_write ##1 (global_tier == TIER_INDIVIDUAL) |=> o_channel_tier == $past(tier_bits);
   endproperty
   a_channel_tier: assert property (p_channel_tier) else $error("channel tier not applied"); // [R5]
   property p_global_tier;
      (global_tier != TIER_INDIVIDUAL) |=> o_channel_tier == {NUM_CHANNELS{$past(global_tier)}};
   endproperty
   a_global_tier: assert property (p_global_tier) else $error("global tier not applied"); // [R6]
   property p_clock_off;
      (mco_select == MCO_OFF) [*2] |-> !o_master_clock_out;
   endproperty
   a_clock_off: assert property (p_clock_off) else $error("clock out not held low"); // [R9]
   property p_clock_buffer;
      (mco_select == MCO_BUFFER) |=> o_master_clock_out == $past(mck_sync);
   endproperty
   a_clock_buffer: assert property (p_clock_buffer) else $error("clock out not buffered"); // [R9]
   property p_rate_ratios;
      (rate_code == SR_96K) && !direct_req |=> o_oversample_ratio == 9'h080
         && o_core_clock_ratio == 10'h100 && o_effective_mclk_ratio == ($past(mcs_ratio) >> 1);
   endproperty
   a_rate_ratios: assert property (p_rate_ratios) else $error("96k ratios wrong"); // [R13]
   property p_low_delay;
      (rate_code == SR_192K_LOWDELAY) |=> o_short_filter && o_core_clock_ratio == 10'h080
         && o_oversample_ratio == 9'h040;
   endproperty
   a_low_delay: assert property (p_low_delay) else $error("low delay mode wrong"); // [R4]
   property p_pll_on;
      !pll_down |=> o_pll_enable && !o_direct_clock;
   endproperty
   a_pll_on: assert property (p_pll_on) else $error("pll not enabled"); // [R15]
   property p_direct;
      direct_req && (rate_code == SR_48K) |=> o_direct_clock && o_effective_mclk_ratio == 10'h200;
   endproperty
   a_direct: assert property (p_direct) else $error("direct clock mode wrong"); // [R17]
   property p_frame_ref;
      (pll_source == SRC_FRAME) |=> o_pll_reference == $past(frm_sync);
   endproperty
   a_frame_ref: assert property (p_frame_ref) else $error("pll reference not frame"); // [R18]
   property p_strap;
      $rose(sa_ready) |-> standalone == $past(sa_sync) ##1 $stable(standalone) [*4];
   endproperty
   a_strap: assert property (p_strap) else $error("strap not captured once"); // [R7]

endmodule

/* File: design/dac_clock_pkg.sv */
package dac_clock_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_CHANNELS = 16;
   localparam int SERIAL_INPUTS = 6;
   localparam int TDM_MAX_CHANNELS = 16;
   localparam int ATTEN_STEPS = 255;
   localparam int ATTEN_STEP_MDB = 375;

   // ----------------------------------------------------------------
   // Register offsets on the serial control port
   // ----------------------------------------------------------------
   localparam logic [6:0] OFS_PLL_CTRL0 = 7'h00;
   localparam logic [6:0] OFS_PLL_CTRL1 = 7'h01;
   localparam logic [6:0] OFS_CONV_CTRL0 = 7'h02;
   localparam logic [6:0] OFS_TIER_FIRST = 7'h03;
   localparam logic [6:0] OFS_TIER_LAST = 7'h06;
   localparam logic [6:0] OFS_BLOCK_PDN = 7'h07;
   localparam logic [6:0] OFS_STATUS = 7'h08;
   localparam logic [2:0] OFS_ATTEN_PAGE = 3'h1;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL0_PUP_BIT = 0;
   localparam int CTRL0_MRS_LSB = 1;
   localparam int CTRL0_SRC_LSB = 6;
   localparam int CTRL1_DIRECT_BIT = 0;
   localparam int CTRL1_MCO_LSB = 4;
   localparam int CTRL1_TIER_LSB = 6;
   localparam int CONV_SR_LSB = 1;
   localparam int CONV_TDM_BIT = 6;
   localparam int CONV_MASTER_BIT = 7;
   localparam int PDN_PLL_BIT = 1;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [7:0] PLL_CTRL0_RST = 8'h00;
   localparam logic [7:0] PLL_CTRL1_RST = 8'h20;
   localparam logic [7:0] CONV_CTRL0_RST = 8'h00;
   localparam logic [31:0] TIER_RST = 32'h0000_0000;
   localparam logic [7:0] BLOCK_PDN_RST = 8'h00;
   localparam logic [7:0] ATTEN_RST = 8'h00;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] MCO_LOWJIT_LOW = 2'h0;
   localparam logic [1:0] MCO_LOWJIT_HIGH = 2'h1;
   localparam logic [1:0] MCO_BUFFER = 2'h2;
   localparam logic [1:0] MCO_OFF = 2'h3;
   localparam logic [1:0] SR_48K = 2'h0;
   localparam logic [1:0] SR_96K = 2'h1;
   localparam logic [1:0] SR_192K_LOWDELAY = 2'h3;
   localparam logic [1:0] SRC_FRAME = 2'h1;
   localparam logic [1:0] TIER_INDIVIDUAL = 2'h0;
   localparam logic [1:0] TIER_LOW = 2'h2;
   localparam logic [1:0] TIER_LOWEST = 2'h3;

   // ----------------------------------------------------------------
   // Clock ratios, referenced to the 48 kHz range
   // ----------------------------------------------------------------
   localparam logic [9:0] MCS_RATIO_0 = 10'h100;
   localparam logic [9:0] MCS_RATIO_1 = 10'h180;
   localparam logic [9:0] MCS_RATIO_2 = 10'h200;
   localparam logic [9:0] MCS_RATIO_3 = 10'h300;
   localparam logic [9:0] DIRECT_RATIO = 10'h200;
   localparam logic [9:0] CORE_RATIO_48K = 10'h200;
   localparam logic [8:0] OSR_48K = 9'h100;

   // ----------------------------------------------------------------
   // Counts and control port framing
   // ----------------------------------------------------------------
   localparam logic [1:0] SA_SETTLE_CYCLES = 2'h2;
   localparam logic [4:0] SPI_ADDR_LAST_BIT = 5'h07;
   localparam logic [4:0] SPI_FRAME_LAST_BIT = 5'h0F;

   typedef enum logic [3:0] {
      SPI_IDLE = 4'b0001,
      SPI_ADDR = 4'b0010,
      SPI_DATA = 4'b0100,
      SPI_WAIT = 4'b1000
   } spi_state_type;

endpackage

/* File: design/atten_store.sv */
`timescale 1ns/1ps
module atten_store
   import dac_clock_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int WIDTH = 8,
   parameter int INDEX_BITS = 4
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_write,
   input wire logic [INDEX_BITS-1:0] i_write_index,
   input wire logic [WIDTH-1:0] i_write_data,
   input wire logic [INDEX_BITS-1:0] i_read_index_a,
   output logic [WIDTH-1:0] o_read_data_a,
   input wire logic [INDEX_BITS-1:0] i_read_index_b,
   output logic [WIDTH-1:0] o_read_data_b
);

   // ----------------------------------------------------------------
   // Entries, one attenuator level per channel
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] entry [DEPTH];

   // Each entry written alone, cleared to 0 dB at reset
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge i_clock or negedge i_rst_n) begin
         if (!i_rst_n) begin
            entry[i] <= WIDTH'(ATTEN_RST);
         end else if (i_write && i_write_index == INDEX_BITS'(i)) begin
            entry[i] <= i_write_data;
         end
      end
   end

   // Registered read ports: one for the control port, one for the datapath
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_read_data_a <= '0;
         o_read_data_b <= '0;
      end else begin
         o_read_data_a <= entry[i_read_index_a];
         o_read_data_b <= entry[i_read_index_b];
      end
   end

endmodule

/* File: tb/clock_source.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far-side master and frame clock source
// ----------------------------------------------------------------
module clock_source #(
   parameter int HALF_NS = 25,
   parameter int FRAME_DIV = 8
) (
   output logic o_master_clock,
   output logic o_frame_clock
);
   int count;
   // Frame clock is cut from the master so the pair stays coherent
   initial begin
      o_master_clock = 1'b0;
      o_frame_clock = 1'b0;
      count = 0;
      forever begin
         #(HALF_NS) o_master_clock = ~o_master_clock;
         count++;
         if (count == FRAME_DIV) begin
            count = 0;
            o_frame_clock = ~o_frame_clock;
         end
      end
   end
endmodule

/* File: tb/dac_clock_config_tb.sv */
`timescale 1ns/1ps
module dac_clock_config_tb;
   import dac_clock_pkg::*;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic clk = 1'b0, rst_n = 1'b0, sel_n = 1'b1, sclk = 1'b0, mosi = 1'b0, strap = 1'b0;
   logic [3:0] ach = 4'h0;
   logic miso, mco, pref, pll_en, direct, smaster, tdm, short_f, oe, oe_seen, pup, sa_o;
   logic [7:0] atten, d;
   logic [8:0] osr;
   logic [9:0] core, eff;
   logic [31:0] tier;
   logic [3:0] now_v, prev_v;
   wire mclk, fclk;
   int fail_count = 0, tests_run = 0, cycles = 0, sh, n [4];
   int dv [4] = '{1, 2, 1, 0};
   logic [1:0] cd [4] = '{MCO_BUFFER, MCO_LOWJIT_LOW, MCO_LOWJIT_HIGH, MCO_OFF};
   logic [9:0] mr [4] = '{MCS_RATIO_0, MCS_RATIO_1, MCS_RATIO_2, MCS_RATIO_3};
   assign now_v = {pref, mco, fclk, mclk};
   clock_source u_clock_source (.o_master_clock(mclk), .o_frame_clock(fclk));
   dac_clock_config u_dac_clock_config (.i_clock(clk), .i_rst_n(rst_n),
      .i_spi_select_n(sel_n), .i_spi_clock(sclk), .i_spi_data_in(mosi),
      .o_spi_data_out(miso), .o_spi_data_out_oe(oe), .i_standalone_select(strap),
      .i_master_clock_in(mclk), .i_frame_clock_in(fclk), .i_atten_channel(ach),
      .o_atten_level(atten), .o_master_clock_out(mco), .o_pll_reference(pref),
      .o_pll_enable(pll_en), .o_direct_clock(direct), .o_powered_up(pup),
      .o_standalone(sa_o), .o_serial_master(smaster), .o_serial_tdm(tdm),
      .o_short_filter(short_f), .o_oversample_ratio(osr), .o_core_clock_ratio(core),
      .o_effective_mclk_ratio(eff), .o_channel_tier(tier));
   // ----------------------------------------------------------------
   // Clock, edge counters, timeout
   // ----------------------------------------------------------------
   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      for (int k = 0; k < 4; k++) if (now_v[k] !== prev_v[k]) n[k]++;
      prev_v <= now_v;
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         wrap_up();
      end
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task cyc(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Mode 0 frame; half period of 5 clocks leaves room for the pin sync
   task xfer(input logic [15:0] f, output logic [7:0] r);
      sel_n = 1'b0;
      cyc(5);
      for (int i = 15; i >= 0; i--) begin
         mosi = f[i];
         cyc(5);
         sclk = 1'b1;
         if (i < 8) r[i] = miso;
         if (i == 0) oe_seen = oe;
         cyc(5);
         sclk = 1'b0;
      end
      cyc(5);
      sel_n = 1'b1;
      cyc(5);
   endtask
   task wr(input logic [6:0] a, input logic [7:0] v);
      logic [7:0] r;
      xfer({1'b0, a, v}, r);
   endtask
   task rd(input logic [6:0] a, output logic [7:0] r);
      xfer({1'b1, a, 8'h00}, r);
   endtask
   // Control frames only start once the reset pin is high
   task do_reset(input logic s);
      strap = s;
      rst_n = 1'b0;
      cyc(8);
      rst_n = 1'b1;
      cyc(8);
   endtask
   task meas;
      for (int k = 0; k < 4; k++) n[k] = 0;
      cyc(400);
   endtask
   task wrap_up;
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      do_reset(1'b0);
      check({pll_en, smaster, tdm, direct}, 4'h8);
      check({osr, core, eff}, {9'h100, 10'h200, 10'h100});
      check({sa_o, pup}, 2'b00);
      rd(7'h01, d);
      check(d, 8'h20);
      check(oe_seen, 1'b1);
      rd(7'h20, d);
      check(d, 8'h00);
      wr(7'h02, 8'h40);
      check(tdm, 1'b1);
      for (int k = 0; k < 4; k++) begin
         wr(7'h02, {5'h00, k[1:0], 1'b0});
         sh = (k == 0) ? 0 : (k == 1) ? 1 : 2;
         check({osr, core}, {9'h100 >> sh, 10'h200 >> sh});
         check({eff, short_f}, {10'h100 >> sh, k == 3});
      end
      wr(7'h02, 8'h02);
      for (int k = 0; k < 4; k++) begin
         wr(7'h00, {5'h00, k[1:0], 1'b0});
         check(eff, mr[k] >> 1);
      end
      wr(7'h07, 8'h02);
      wr(7'h01, 8'h21);
      check({pll_en, direct, eff}, {2'b01, 10'h100});
      wr(7'h01, 8'h20);
      wr(7'h07, 8'h00);
      wr(7'h03, 8'h0E);
      check(tier, 32'h0000000E);
      wr(7'h01, 8'hE0);
      check(tier, 32'hFFFFFFFF);
      wr(7'h01, 8'h20);
      check(tier, 32'h0000000E);
      wr(7'h1F, 8'hFF);
      ach = 4'hF;
      cyc(2);
      check(atten, 8'hFF);
      rd(7'h1F, d);
      check(d, 8'hFF);
      wr(7'h00, 8'h00);
      for (int j = 0; j < 4; j++) begin
         wr(7'h01, {2'b00, cd[j], 4'h0});
         meas();
         check(dv[j] == 0 ? n[2] == 0 : n[2] * dv[j] + 3 >= n[0] && n[2] * dv[j] <= n[0] + 3, 1'b1);
      end
      wr(7'h00, 8'h41);
      check({pup, oe_seen}, 2'b10);
      meas();
      check(n[3] + 2 >= n[1] && n[3] <= n[1] + 2, 1'b1);
      do_reset(1'b1);
      check({sa_o, pup}, 2'b10);
      wr(7'h02, 8'h80);
      check(smaster, 1'b0);
      wrap_up();
   end
endmodule
